// ==== include/dsm_regs.vh ====
// Register map, field positions and reset values of the signal modulator.
// Assumes an APB slave with 32-bit data; each 8-bit register takes a word.
`ifndef DSM_REGS_VH
`define DSM_REGS_VH

// -----------------------------------------------------------------------
// Register indices and address width
// -----------------------------------------------------------------------
`define DSM_IDX_CTRL_MAIN   12'h0f51
`define DSM_IDX_CARR_CTRL   12'h0f52
`define DSM_IDX_SRC_SEL     12'h0f53
`define DSM_IDX_CARRIER_LOW_SIGNAL_SEL    12'h0f54
`define DSM_IDX_CARRIER_HIGH_SIGNAL_SEL    12'h0f55
`define DSM_IDX_POWER       12'h0f60
`define DSM_ADDR_W          14

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define DSM_EN_BIT          7
`define DSM_OUT_BIT         5
`define DSM_OINV_BIT        4
`define DSM_SOFT_BIT        0
`define DSM_CHINV_BIT       5
`define DSM_CARRIER_HIGH_SYNC_ENABLE_BIT      4
`define DSM_CLINV_BIT       1
`define DSM_CARRIER_LOW_SYNC_ENABLE_BIT      0

// -----------------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------------
`define DSM_RST_BYTE        8'h00
`define DSM_SRC_SOFT        4'h1
`define DSM_CTRL_MASK       8'hb1
`define DSM_CARR_MASK       8'h33

`endif

// ==== logic/dsm_mod_src.v ====
// Sixteen-way modulator source selector; codes 14 and 15 read as low.
// Assumes the sources are synchronous to the register clock.
module dsm_mod_src (
    // Selection
    input  wire [3:0]  sel,
    input  wire [13:0] src,
    // Result
    output reg         y
);
    always @* begin
        if (sel > 4'hd) begin
            y = 1'b0;
        end else begin
            y = src[sel];
        end
    end
endmodule

// ==== logic/dsm_mux8.v ====
// Eight-way one-bit source selector for a carrier.
// Assumes the sources are synchronous to the register clock.
module dsm_mux8 (
    // Selection
    input  wire [2:0] sel,
    input  wire [7:0] src,
    // Result
    output wire       y
);
    assign y = src[sel];
endmodule

// ==== logic/dsm_top.v ====
// Data signal modulator: carrier selection, polarity, sync and mixing.
// Assumes APB access from software and all sources synchronous to pclk.
//
// Operation
// - Output is modulator AND the currently selected carrier, except while carrier-high sync holds carrier high after modulator falls.
// - Modulator high mixes carrier high; low mixes carrier low (code ANDs carrier low with the modulator, so modulator low never passes it).
// - Enable clear holds the pin low and keeps all selections.
// - Carrier invert bits invert the selected high and low carriers.
// - A software bit can serve as modulation source.
// - Output invert bit inverts the output; idle high when set.
// - Enable set mixes inputs; clear gives no output.
// - A status bit shows the present modulated output value.
// - Block keeps running in sleep if its sources keep running.
// - Any reset disables the block and clears all registers.
// - Power-down holds the block inactive; release leaves defaults.
// - Carrier-high sync waits for carrier high to be low before switching.
// - Carrier-low sync waits for carrier low to be low before switching.
// - Unsynchronised carriers switch at once; spurs may appear.
// - Carrier-high code picks pin, clocks, capture or pulse units.
// - Carrier-low code uses same encoding, own routed pin at 000.
// - Four-bit modulator code maps fourteen sources; 14 and 15 reserved.
`include "dsm_regs.vh"

module dsm_top (
    // APB
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Power-down control
    input  wire        modulator_power_down,
    // Carrier sources
    input  wire        carrier_high_pin_route,
    input  wire        carrier_low_pin_route,
    input  wire        system_clock_source,
    input  wire        internal_fast_oscillator,
    input  wire        reference_clock_output,
    input  wire        capture_unit_one,
    input  wire        capture_unit_two,
    input  wire        pulse_unit_three,
    input  wire        pulse_unit_four,
    // Modulator sources
    input  wire        modulator_source_pin_route,
    input  wire        comparator_one,
    input  wire        comparator_two,
    input  wire [3:0]  async_serial_lines,
    input  wire        sync_serial_one,
    input  wire        sync_serial_two,
    // Modulated output
    output reg         modulated_output_pin
);

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    reg  [7:0] ctrl_main_r;
    reg  [7:0] carr_ctrl_r;
    reg  [3:0] modulator_source_code_r;
    reg  [2:0] carrier_low_code_r;
    reg  [2:0] carrier_high_code_r;
    reg        pd_r;
    reg        use_high_r;
    reg        carrier_high_signal_d_r;
    reg        carrier_low_signal_d_r;

    wire       sel_raw_h;
    wire       sel_raw_l;
    wire       modulator_signal;
    wire       carrier_high_signal;
    wire       carrier_low_signal;
    wire       enable;
    wire       acc;
    wire       wr;
    wire       hit;
    wire [11:0] idx;
    reg        use_high_nxt;
    reg        mix;
    reg        out_nxt;

    assign enable = ctrl_main_r[`DSM_EN_BIT] & ~pd_r;
    assign acc    = psel & penable & clk_en;
    assign wr     = acc & pwrite & ~pd_r;
    assign idx    = paddr[`DSM_ADDR_W-1:2];
    assign hit    = (paddr[1:0] == 2'b00) && (paddr[15:`DSM_ADDR_W] == 2'b00);

    // -------------------------------------------------------------------
    // Source selection
    // -------------------------------------------------------------------
    dsm_mux8 u_carrier_high_signal (
        .sel (carrier_high_code_r),
        .src ({pulse_unit_four, pulse_unit_three, capture_unit_two,
               capture_unit_one, reference_clock_output,
               internal_fast_oscillator, system_clock_source,
               carrier_high_pin_route}),
        .y   (sel_raw_h)
    );

    dsm_mux8 u_carrier_low_signal (
        .sel (carrier_low_code_r),
        .src ({pulse_unit_four, pulse_unit_three, capture_unit_two,
               capture_unit_one, reference_clock_output,
               internal_fast_oscillator, system_clock_source,
               carrier_low_pin_route}),
        .y   (sel_raw_l)
    );

    // Soft bit sits at code 0001; other codes ignore it.
    dsm_mod_src u_mod (
        .sel (modulator_source_code_r),
        .src ({sync_serial_two, sync_serial_one, async_serial_lines,
               comparator_two, comparator_one, pulse_unit_four,
               pulse_unit_three, capture_unit_two, capture_unit_one,
               ctrl_main_r[`DSM_SOFT_BIT], modulator_source_pin_route}),
        .y   (modulator_signal)
    );

    // Polarity ahead of sync and mixing.
    assign carrier_high_signal = sel_raw_h
                               ^ carr_ctrl_r[`DSM_CHINV_BIT];
    assign carrier_low_signal  = sel_raw_l
                               ^ carr_ctrl_r[`DSM_CLINV_BIT];

    // -------------------------------------------------------------------
    // Carrier switching and mixing
    // -------------------------------------------------------------------
    always @* begin
        use_high_nxt = use_high_r;
        if (modulator_signal && !use_high_r) begin
            // Switch to high waits for carrier low to be low when synced.
            if (!carr_ctrl_r[`DSM_CARRIER_LOW_SYNC_ENABLE_BIT] ||
                (carrier_low_signal_d_r && !carrier_low_signal) ||
                !carrier_low_signal) begin
                use_high_nxt = 1'b1;
            end
        end else if (!modulator_signal && use_high_r) begin
            if (!carr_ctrl_r[`DSM_CARRIER_HIGH_SYNC_ENABLE_BIT] ||
                !carrier_high_signal) begin
                use_high_nxt = 1'b0;
            end
        end
        // Unsynchronised switching is immediate.
        if (use_high_nxt) begin
            mix = carrier_high_signal;
        end else begin
            mix = carrier_low_signal;
        end
        if (!carr_ctrl_r[`DSM_CARRIER_HIGH_SYNC_ENABLE_BIT] &&
            !carr_ctrl_r[`DSM_CARRIER_LOW_SYNC_ENABLE_BIT]) begin
            mix = mix & modulator_signal;
        end else if (use_high_nxt) begin
            mix = mix & (modulator_signal | use_high_r);
        end else begin
            mix = mix & modulator_signal;
        end
        if (enable) begin
            out_nxt = mix ^ ctrl_main_r[`DSM_OINV_BIT];
        end else begin
            out_nxt = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_high_r           <= 1'b0;
            carrier_high_signal_d_r             <= 1'b0;
            carrier_low_signal_d_r             <= 1'b0;
            modulated_output_pin <= 1'b0;
        end else if (clk_en) begin
            // Runs on pclk gated only by clk_en, so sleep does not stop it.
            use_high_r           <= use_high_nxt & enable;
            carrier_high_signal_d_r             <= carrier_high_signal;
            carrier_low_signal_d_r             <= carrier_low_signal;
            modulated_output_pin <= out_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_main_r             <= `DSM_RST_BYTE;
            carr_ctrl_r             <= `DSM_RST_BYTE;
            modulator_source_code_r <= 4'h0;
            carrier_low_code_r      <= 3'h0;
            carrier_high_code_r     <= 3'h0;
            pd_r                    <= 1'b0;
        end else if (clk_en) begin
            pd_r <= modulator_power_down;
            if (pd_r) begin
                ctrl_main_r             <= `DSM_RST_BYTE;
                carr_ctrl_r             <= `DSM_RST_BYTE;
                modulator_source_code_r <= 4'h0;
                carrier_low_code_r      <= 3'h0;
                carrier_high_code_r     <= 3'h0;
            end else if (wr && hit) begin
                case (idx)
                    `DSM_IDX_CTRL_MAIN: begin
                        ctrl_main_r <= pwdata[7:0] & `DSM_CTRL_MASK
                                       & ~(8'h01 << `DSM_OUT_BIT);
                    end
                    `DSM_IDX_CARR_CTRL: begin
                        carr_ctrl_r <= pwdata[7:0] & `DSM_CARR_MASK;
                    end
                    `DSM_IDX_SRC_SEL: begin
                        modulator_source_code_r <= pwdata[3:0];
                    end
                    `DSM_IDX_CARRIER_LOW_SIGNAL_SEL: begin
                        carrier_low_code_r <= pwdata[2:0];
                    end
                    `DSM_IDX_CARRIER_HIGH_SIGNAL_SEL: begin
                        carrier_high_code_r <= pwdata[2:0];
                    end
                    default: begin
                        ctrl_main_r <= ctrl_main_r;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // APB answer
    // -------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (!hit) begin
                    pslverr <= 1'b1;
                end else begin
                    case (idx)
                        `DSM_IDX_CTRL_MAIN: begin
                            prdata[7:0] <= ctrl_main_r |
                                ({7'h00, modulated_output_pin}
                                 << `DSM_OUT_BIT);
                        end
                        `DSM_IDX_CARR_CTRL: begin
                            prdata[7:0] <= carr_ctrl_r;
                        end
                        `DSM_IDX_SRC_SEL: begin
                            prdata[3:0] <= modulator_source_code_r;
                        end
                        `DSM_IDX_CARRIER_LOW_SIGNAL_SEL: begin
                            prdata[2:0] <= carrier_low_code_r;
                        end
                        `DSM_IDX_CARRIER_HIGH_SIGNAL_SEL: begin
                            prdata[2:0] <= carrier_high_code_r;
                        end
                        default: begin
                            pslverr <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

endmodule

// ==== tb/data_signal_modulator_tb.sv ====
// Testbench of the signal modulator: APB master, source model, checks.
// Assumes the register byte address is four times the register index.
module data_signal_modulator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pd, run;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, out;
    wire  [17:0] lv;
    logic [7:0]  r [0:4];
    int          mismatches, samples_checked, cyc;
    dsm_src_model src (.pclk(pclk), .run(run), .lv(lv));
    dsm_top uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modulator_power_down(pd),
        .carrier_high_pin_route(lv[0]), .carrier_low_pin_route(lv[1]),
        .system_clock_source(lv[2]), .internal_fast_oscillator(lv[3]),
        .reference_clock_output(lv[4]), .capture_unit_one(lv[5]),
        .capture_unit_two(lv[6]), .pulse_unit_three(lv[7]),
        .pulse_unit_four(lv[8]), .modulator_source_pin_route(lv[9]),
        .comparator_one(lv[10]), .comparator_two(lv[11]),
        .async_serial_lines(lv[15:12]), .sync_serial_one(lv[16]),
        .sync_serial_two(lv[17]), .modulated_output_pin(out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [7:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'($urandom), d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] msk(input int k);
        return k == 0 ? 8'h91 : k == 1 ? 8'h33 : k == 2 ? 8'h0f : 8'h07;
    endfunction
    task automatic wr(input int k, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, 16'h3d44 + 16'(4 * k), d, q, e);
        r[k] = d & msk(k);
        chk(32'(e), 32'h0000_0000);
    endtask
    task automatic rd(input int k, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b0, 16'h3d44 + 16'(4 * k), 8'h00, q, e);
        chk(q, {24'h00_0000, d});
    endtask
    // Expected output from the shadow registers and the present sources.
    function automatic logic ex();
        logic [7:0]  h, l;
        logic [15:0] m;
        logic        md, c;
        h = {lv[8:2], lv[0]};
        l = {lv[8:2], lv[1]};
        m = {2'h0, lv[17:10], lv[8:5], r[0][0], lv[9]};
        md = m[r[2][3:0]];
        c = md ? h[r[4][2:0]] ^ r[1][5] : l[r[3][2:0]] ^ r[1][1];
        return r[0][7] & ((c & md) ^ r[0][4]);
    endfunction
    task automatic watch(input int n);
        logic e;
        @(negedge pclk);
        e = ex();
        repeat (n) begin
            @(negedge pclk);
            chk(32'(out), 32'(e));
            e = ex();
        end
    endtask
    task automatic all_zero(input string s);
        for (int k = 0; k < 5; k++) begin
            r[k] = 8'h00;
            rd(k, 8'h00);
        end
        $display("test %s done", s);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        logic [31:0] q;
        logic        e;
        {psel, penable, pwrite, pd, run, presetn} = 6'h00;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(11393));
        run <= 1'b1;
        all_zero("reset");
        for (int k = 1; k < 5; k++) begin
            wr(k, 8'($urandom));
            rd(k, r[k]);
        end
        apb(1'b0, 16'h3d58, 8'h00, q, e);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, 16'h3d45, 8'h80, q, e);
        chk(32'(e), 32'h0000_0001);
        rd(0, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            wr(1, 8'($urandom) & 8'h22);
            wr(2, 8'(i));
            wr(3, 8'(~i));
            wr(4, 8'(i));
            wr(0, 8'h80 | (8'($urandom) & 8'h11));
            watch(24);
        end
        $display("test mixing done");
        wr(2, 8'h01);
        wr(0, 8'h81);
        watch(8);
        wr(0, 8'h90);
        watch(4);
        rd(0, 8'hb0);
        wr(0, 8'h10);
        watch(8);
        rd(2, 8'h01);
        wr(0, 8'h91);
        watch(8);
        $display("test soft bit done");
        pd <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(out), 32'h0000_0000);
        pd <= 1'b0;
        repeat (2) @(posedge pclk);
        all_zero("power-down");
        wr(0, 8'h90);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        all_zero("second reset");
        end_of_test();
    end
endmodule
bind dsm_top dsm_sva chk_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .modulator_power_down(modulator_power_down),
    .modulated_output_pin(modulated_output_pin));

// ==== tb/dsm_src_model.sv ====
// Model of the peripheral outputs, clocks and pins feeding the modulator.
// Assumes every source is a level synchronous to pclk.
module dsm_src_model (
    input  wire         pclk,
    input  wire         run,
    output logic [17:0] lv
);
    initial lv = 18'h0_0000;
    // Sources keep toggling whenever run is high, sleep included.
    always @(posedge pclk) begin
        if (run) begin
            lv <= 18'($urandom);
        end
    end
endmodule

// ==== tb/dsm_sva.sv ====
// Checker on the ports of the signal modulator top.
// Assumes clk_en high and software writes in the low byte lane.
module dsm_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        modulator_power_down,
    input wire        modulated_output_pin
);
    logic [7:0] main_r;
    logic [3:0] src_r;
    wire        wr = psel && penable && pready && pwrite && !pslverr;
    wire        out = modulated_output_pin;
    wire        soft_sel = main_r[7] && src_r == 4'h1 && !main_r[0];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Shadow of the control and source bytes, cleared with the block.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || modulator_power_down) begin
            main_r <= 8'h00;
            src_r  <= 4'h0;
        end else if (wr && paddr == 16'h3d44) begin
            main_r <= pwdata[7:0];
        end else if (wr && paddr == 16'h3d4c) begin
            src_r <= pwdata[3:0];
        end
    end
    reset_quiet_a: assert property (disable iff (1'b0)
        !presetn |-> !out) else $error("output high in reset");
    pwrdn_quiet_a: assert property (
        modulator_power_down [*5] |-> !out)
        else $error("output high in power-down");
    off_low_a: assert property (disable iff (!presetn || modulator_power_down)
        !main_r[7] |=> !out) else $error("output high while disabled");
    idle_high_a: assert property (disable iff (!presetn || modulator_power_down)
        soft_sel && main_r[4] |=> out) else $error("inverted idle not high");
    soft_low_a: assert property (disable iff (!presetn || modulator_power_down)
        soft_sel && !main_r[4] |=> !out) else $error("soft zero not low");
    reserved_src_a: assert property (disable iff (!presetn || modulator_power_down)
        main_r[7] && !main_r[4] && src_r[3:1] == 3'h7 |=> !out)
        else $error("reserved source not low");
    ready_next_a: assert property (
        psel && !penable && clk_en |=> pready) else $error("no ready");
    bad_addr_a: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
endmodule
